// *** design/sewp_pkg.sv ***
/*
 Constants shared by the serial EEPROM write port: control codes, address
 byte fields, bit counts, page geometry and write cycle timing.
 Assumes a single 25 MHz system clock.
*/
`default_nettype none

package sewp_pkg;

    // System clock
    localparam int CLK_HZ = 25_000_000;

    // Self-timed write cycle, longest time, in milliseconds
    localparam int WR_TIME_MS = 5;
    // Longest time rounds down to whole cycles
    localparam int WR_CYCLES = (WR_TIME_MS * (CLK_HZ / 1000));

    // Control codes in the device address byte
    localparam logic [3:0] CTL_ARRAY = 4'ha;
    localparam logic [3:0] CTL_PROT = 4'h6;

    // Device address byte fields
    localparam int CTL_MSB = 7;
    localparam int CTL_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT = 0;

    // Word framing
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;

    // Array geometry: 16 pages of 16 bytes
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_AW = 4;
    localparam int HALF_BIT = 7;
    localparam logic [3:0] LAST_IDX = 4'hf;

    // Data path buffer depth
    localparam int FIFO_DEPTH = 8;

endpackage

`default_nettype wire

// *** design/sewp_fifo.sv ***
/*
 Small synchronous FIFO with valid/ready on both sides; storage in flops.
 Assumes both sides run on the same clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none

module sewp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words
    logic [AW-1:0] wr_q, wr_d; // Write index
    logic [AW-1:0] rd_q, rd_d; // Read index
    logic [AW:0] cnt_q, cnt_d; // Fill level
    logic push; // Word accepted
    logic pop; // Word taken

    // Full and empty come from the fill level, never from pointers alone
    assign in_ready = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers and level
    always_comb
    begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            // Wrap at depth, which need not be a power of two
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Register pointers and storage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule // sewp_fifo

`default_nettype wire

// *** design/sewp_top.sv ***
/*
 Two-wire target front end of a 256-byte serial EEPROM: start/stop
 detection, device address check, byte and 16-byte page writes, write
 protection, self-timed write cycle and acknowledge polling.
 Assumes SCL and SDA come from pins (resolved open-drain levels) and
 that the array sits outside, taking one byte write per mem_we pulse.
*/
// Behaviour
// - SDA changes with SCL high are conditions
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Eight bits MSB first, ack on ninth
// - Standby at reset and after stop
// - Code 1010 is array, 0110 protect
// - Select bits must match strap pins
// - Address LSB one reads, zero writes
// - Mismatch: no ack, back to standby
// - Programmed protect: no ack for 0110
// - Byte write: address, word address, data
// - Stop starts write cycle, bus ignored
// - Protected writes acked but data dropped
// - Page write takes up to sixteen bytes
// - Only low four address bits increment
// - Extra page bytes overwrite earlier ones
// - Polling acked only after write cycle
// - Protect pin high blocks all writes
// - Software protection covers lower half only
// - Sixteen pages of sixteen bytes
`timescale 1ns/1ns
`default_nettype none

module sewp_top #(
    parameter int WR_CYCLES = sewp_pkg::WR_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Straps and protection
    input wire logic select_pin_2,
    input wire logic select_pin_1,
    input wire logic select_pin_0,
    input wire logic wp_pin,
    input wire logic reversible_protect_reg,
    output logic permanent_protect_reg,
    // Array write port
    output logic mem_we,
    output logic [7:0] mem_addr,
    output logic [7:0] mem_wdata,
    // Status
    output logic busy,
    output logic standby
);

    localparam int CW = $clog2(WR_CYCLES + 1);
    localparam int PW = sewp_pkg::PAGE_AW;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_WADDR, ST_DATA, ST_PROT, ST_IGNORE, ST_BUSY
    } sewp_state_t;

    // Two-flop synchronisers per pin plus one edge stage for SCL and SDA
    logic [5:0] pin_s1_q, pin_s2_q; // scl, sda, sel[2:0], wp
    logic rsw_s1_q, rsw_s2_q; // Reversible protect level
    logic scl_d3_q, sda_d3_q; // Previous synced levels

    // Control group
    sewp_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d; // Bit position in word
    logic [7:0] sh_q, sh_d; // Incoming shift register
    logic [7:0] addr_q, addr_d; // Word address
    logic oe_q, oe_d; // SDA pulled low
    logic pend_q, pend_d; // Array write owed at stop
    logic prq_q, prq_d; // Protect write owed at stop
    logic perm_q, perm_d; // Permanent protect programmed
    logic [CW-1:0] wcnt_q, wcnt_d; // Write cycle countdown
    logic busy_q, standby_q;

    // Page buffer and array port group
    logic [7:0] pb_q [sewp_pkg::PAGE_BYTES];
    logic [sewp_pkg::PAGE_BYTES-1:0] pv_q, pv_d; // Entry valid
    logic [PW-1:0] pg_q, pg_d; // Page held
    logic arm_q, arm_d; // Waiting for FIFO to empty
    logic fl_q, fl_d; // Flushing to the array
    logic [PW-1:0] fi_q, fi_d; // Flush index
    logic we_q, we_d;
    logic [7:0] ma_q, ma_d, md_q, md_d;

    // Decoded pin events
    logic scl_s, sda_s, wp_s, rsw_s;
    logic [2:0] sel_s;
    logic scl_rise, scl_fall, start, stop;
    logic dec; // Word complete, decide the ack
    logic prot_hit; // Current data byte is protected
    logic go_wr; // Stop that launches a write cycle

    // FIFO links
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [15:0] f_out_data;

    assign scl_s = pin_s2_q[5];
    assign sda_s = pin_s2_q[4];
    assign sel_s = pin_s2_q[3:1];
    assign wp_s = pin_s2_q[0];
    assign rsw_s = rsw_s2_q;
    assign scl_rise = scl_s && !scl_d3_q;
    assign scl_fall = !scl_s && scl_d3_q;
    // Only SDA moves with SCL held high form conditions
    assign start = scl_s && scl_d3_q && sda_d3_q && !sda_s;
    assign stop = scl_s && scl_d3_q && !sda_d3_q && sda_s;
    assign dec = scl_fall && (cnt_q == sewp_pkg::BITS_PER_WORD) &&
                 (st_q != ST_IDLE) && (st_q != ST_BUSY);
    // Pin high guards all; software only guards the lower half
    assign prot_hit = wp_s || (!addr_q[sewp_pkg::HALF_BIT] &&
                      (perm_q || rsw_s));
    assign go_wr = stop && (st_q != ST_BUSY) && (pend_q || prq_q);
    assign f_in_valid = dec && (st_q == ST_DATA) && !prot_hit;
    assign f_out_ready = !fl_q;

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_s1_q <= 6'h30;
            pin_s2_q <= 6'h30;
            rsw_s1_q <= 1'b0;
            rsw_s2_q <= 1'b0;
            scl_d3_q <= 1'b1;
            sda_d3_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= {scl_i, sda_i, select_pin_2, select_pin_1,
                         select_pin_0, wp_pin};
            pin_s2_q <= pin_s1_q;
            rsw_s1_q <= reversible_protect_reg;
            rsw_s2_q <= rsw_s1_q;
            scl_d3_q <= scl_s;
            sda_d3_q <= sda_s;
        end
    end

    // Bus protocol next state
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        addr_d = addr_q;
        oe_d = oe_q;
        pend_d = pend_q;
        prq_d = prq_q;
        perm_d = perm_q;
        wcnt_d = wcnt_q;
        if (st_q == ST_BUSY)
        begin
            // All bus inputs ignored, so polls see no ack
            oe_d = 1'b0;
            if (wcnt_q == '0)
            begin
                st_d = ST_IDLE;
            end
            else
            begin
                wcnt_d = wcnt_q - 1'b1;
            end
        end
        else if (start)
        begin
            // Recognised in any state but ST_BUSY; a repeated start drops owed work
            st_d = ST_DEV;
            cnt_d = '0;
            oe_d = 1'b0;
            pend_d = 1'b0;
            prq_d = 1'b0;
        end
        else if (stop)
        begin
            oe_d = 1'b0;
            cnt_d = '0;
            pend_d = 1'b0;
            prq_d = 1'b0;
            if (go_wr)
            begin
                // Countdown measured from the stop itself
                st_d = ST_BUSY;
                wcnt_d = CW'(WR_CYCLES - 1);
                // Protect register only programmable with pin low
                if (prq_q && !wp_s)
                begin
                    perm_d = 1'b1;
                end
            end
            else
            begin
                st_d = ST_IDLE;
            end
        end
        else if (st_q != ST_IDLE)
        begin
            if (scl_rise && (cnt_q < sewp_pkg::BITS_PER_WORD))
            begin
                // Sample on SCL rise, most significant bit first
                sh_d = {sh_q[6:0], sda_s};
                cnt_d = cnt_q + 1'b1;
            end
            else if (dec)
            begin
                cnt_d = sewp_pkg::ACK_SLOT;
                oe_d = 1'b0;
                case (st_q)
                    ST_DEV:
                    begin
                        if (sh_q[sewp_pkg::SEL_MSB:sewp_pkg::SEL_LSB]
                            != sel_s)
                        begin
                            st_d = ST_IDLE;
                        end
                        else if (sh_q[sewp_pkg::CTL_MSB:sewp_pkg::CTL_LSB]
                                 == sewp_pkg::CTL_ARRAY)
                        begin
                            oe_d = 1'b1;
                            // Reads are acked then left to other logic
                            st_d = sh_q[sewp_pkg::RW_BIT] ? ST_IGNORE
                                                          : ST_WADDR;
                        end
                        else if ((sh_q[sewp_pkg::CTL_MSB:sewp_pkg::CTL_LSB]
                                  == sewp_pkg::CTL_PROT) && !perm_q)
                        begin
                            oe_d = 1'b1;
                            st_d = sh_q[sewp_pkg::RW_BIT] ? ST_IGNORE
                                                          : ST_PROT;
                        end
                        else
                        begin
                            st_d = ST_IDLE;
                        end
                    end
                    ST_WADDR:
                    begin
                        addr_d = sh_q;
                        oe_d = 1'b1;
                        st_d = ST_DATA;
                    end
                    ST_DATA:
                    begin
                        // A full buffer cannot take the byte: no ack
                        if (f_in_ready || prot_hit)
                        begin
                            oe_d = 1'b1;
                            pend_d = 1'b1;
                            // Page kept, low nibble wraps in page
                            addr_d = {addr_q[7:PW],
                                      addr_q[PW-1:0] + 1'b1};
                        end
                        else
                        begin
                            st_d = ST_IGNORE;
                        end
                    end
                    ST_PROT:
                    begin
                        // Word address and data are don't cares
                        oe_d = 1'b1;
                        prq_d = 1'b1;
                    end
                    default:
                    begin
                        oe_d = 1'b0;
                    end
                endcase
            end
            else if (scl_fall && (cnt_q == sewp_pkg::ACK_SLOT))
            begin
                // Release after the ninth clock
                oe_d = 1'b0;
                cnt_d = '0;
            end
        end
    end

    // Bus protocol registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            sh_q <= 8'h00;
            addr_q <= 8'h00;
            oe_q <= 1'b0;
            pend_q <= 1'b0;
            prq_q <= 1'b0;
            perm_q <= 1'b0;
            wcnt_q <= '0;
            busy_q <= 1'b0;
            standby_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            oe_q <= oe_d;
            pend_q <= pend_d;
            prq_q <= prq_d;
            perm_q <= perm_d;
            wcnt_q <= wcnt_d;
            busy_q <= (st_d == ST_BUSY);
            standby_q <= (st_d == ST_IDLE);
        end
    end

    // Page buffer fill and flush next state
    always_comb
    begin
        pv_d = pv_q;
        pg_d = pg_q;
        arm_d = arm_q;
        fl_d = fl_q;
        fi_d = fi_q;
        we_d = 1'b0;
        ma_d = ma_q;
        md_d = md_q;
        if (start && (st_q != ST_BUSY))
        begin
            pv_d = '0; // Aborted transfer writes nothing
        end
        if (f_out_valid && f_out_ready)
        begin
            // Same slot rewritten on rollover: later byte wins
            pv_d[f_out_data[11:8]] = 1'b1;
            pg_d = f_out_data[15:12];
        end
        if (go_wr)
        begin
            arm_d = 1'b1;
        end
        else if (arm_q && !f_out_valid)
        begin
            arm_d = 1'b0;
            fl_d = 1'b1;
            fi_d = '0;
        end
        else if (fl_q)
        begin
            if (pv_q[fi_q])
            begin
                we_d = 1'b1;
                ma_d = {pg_q, fi_q};
                md_d = pb_q[fi_q];
                pv_d[fi_q] = 1'b0;
            end
            fi_d = fi_q + 1'b1;
            fl_d = (fi_q != sewp_pkg::LAST_IDX);
        end
    end

    // Page buffer registers; data slots need no reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pv_q <= '0;
            pg_q <= '0;
            arm_q <= 1'b0;
            fl_q <= 1'b0;
            fi_q <= '0;
            we_q <= 1'b0;
            ma_q <= 8'h00;
            md_q <= 8'h00;
        end
        else
        begin
            pv_q <= pv_d;
            pg_q <= pg_d;
            arm_q <= arm_d;
            fl_q <= fl_d;
            fi_q <= fi_d;
            we_q <= we_d;
            ma_q <= ma_d;
            md_q <= md_d;
        end
        if (f_out_valid && f_out_ready)
        begin
            pb_q[f_out_data[11:8]] <= f_out_data[7:0];
        end
    end

    // Received bytes with their address; stalls while flushing
    sewp_fifo #(
        .WIDTH(16),
        .DEPTH(sewp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data({addr_q, sh_q}),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    assign sda_o = 1'b0; // Open drain: only ever pulls low
    assign sda_oe = oe_q;
    assign permanent_protect_reg = perm_q;
    assign mem_we = we_q;
    assign mem_addr = ma_q;
    assign mem_wdata = md_q;
    assign busy = busy_q;
    assign standby = standby_q;

    // Checks next to the logic they guard
    a_nak_mismatch: assert property (
        @(posedge clk) disable iff (rst)
        dec && st_q == ST_DEV && !start && !stop &&
        sh_q[3:1] != sel_s |=> !sda_oe ##1 standby)
        else $error("ack given on select mismatch");
    a_ack_array: assert property (
        @(posedge clk) disable iff (rst)
        dec && st_q == ST_DEV && !start && !stop && sh_q[3:1] == sel_s &&
        sh_q[7:4] == sewp_pkg::CTL_ARRAY |=> sda_oe)
        else $error("array address not acked");
    a_prot_nak: assert property (
        @(posedge clk) disable iff (rst)
        dec && st_q == ST_DEV && !start && !stop && perm_q &&
        sh_q[7:4] == sewp_pkg::CTL_PROT |=> !sda_oe)
        else $error("protect code acked after programming");
    a_busy_silent: assert property (
        @(posedge clk) disable iff (rst)
        busy |-> !sda_oe)
        else $error("bus driven during write cycle");
    a_busy_hold: assert property (
        @(posedge clk) disable iff (rst)
        st_q == ST_BUSY && wcnt_q != '0 |=> st_q == ST_BUSY)
        else $error("write cycle ended early");
    a_busy_start: assert property (
        @(posedge clk) disable iff (rst)
        go_wr |=> busy && wcnt_q == CW'(WR_CYCLES - 1))
        else $error("stop did not start write cycle");
    a_addr_wrap: assert property (
        @(posedge clk) disable iff (rst)
        dec && st_q == ST_DATA && !start && !stop && f_in_ready |=>
        addr_q[7:4] == $past(addr_q[7:4]) &&
        addr_q[3:0] == $past(addr_q[3:0]) + 4'h1)
        else $error("word address increment wrong");
    // Protection written out apart from prot_hit, so a bad decode shows
    a_prot_drop: assert property (
        @(posedge clk) disable iff (rst)
        dec && st_q == ST_DATA && !start && !stop &&
        (wp_s || (!addr_q[7] && (perm_q || rsw_s))) |->
        !f_in_valid ##1 sda_oe)
        else $error("protected byte queued or not acked");
    a_start_any: assert property (
        @(posedge clk) disable iff (rst)
        start && !busy |=> st_q == ST_DEV && cnt_q == 4'h0)
        else $error("start not recognised");
    a_stop_idle: assert property (
        @(posedge clk) disable iff (rst)
        stop && !busy && !pend_q && !prq_q |=> standby)
        else $error("stop did not reach standby");

endmodule // sewp_top

`default_nettype wire

// *** dv/sewp_ctl_model.sv ***
/*
 Two-wire bus controller model: start, stop, byte and bus recovery.
 Assumes SDA is resolved with a pull-up outside; clk runs at 25 MHz.
*/
`timescale 1ns/1ns
`default_nettype none

module sewp_ctl_model (
    // Clock
    input wire logic clk,
    // Bus
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Half SCL period in clk cycles, 320 ns per bit
    localparam int HALF = 4;

    // Idle bus: clock stands high, data released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Wait n falling clk edges
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One bit; data moves a cycle after SCL falls
    task automatic clk_bit(input logic b, output logic got);
        sda_low = ~b;
        tk(HALF - 1);
        scl = 1'b1;
        tk(HALF);
        got = sda;
        scl = 1'b0;
        tk(1);
    endtask

    // Byte MSB first, then the ack slot
    task automatic send(input logic [7:0] v, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            clk_bit(v[i], g);
        clk_bit(1'b1, g);
        ack = ~g;
        // Longer low so the ack release clears first
        tk(HALF);
    endtask

    // Start, also usable as a repeated start
    task automatic start();
        sda_low = 1'b0;
        tk(HALF);
        scl = 1'b1;
        tk(HALF);
        sda_low = 1'b1;
        tk(HALF);
        scl = 1'b0;
        tk(1);
    endtask

    // Stop; bus then idles with SCL still
    task automatic stop();
        sda_low = 1'b1;
        tk(HALF);
        scl = 1'b1;
        tk(HALF);
        sda_low = 1'b0;
        tk(2 * HALF);
    endtask

    // Bus recovery: start, nine clocks, start, stop
    task automatic recover();
        logic g;
        start();
        repeat (9) clk_bit(1'b1, g);
        start();
        stop();
    endtask
endmodule // sewp_ctl_model

`default_nettype wire

// *** dv/sewp_top_tb.sv ***
/*
 Bench for the EEPROM write port: controller model drives the bus,
 tasks run write sequences and check acks, flags and array writes.
 Assumes a shortened write cycle through WR_CYCLES.
*/
`timescale 1ns/1ns
`default_nettype none

module sewp_top_tb;
    // Short write cycle keeps the run brief
    localparam int WRC = 300;
    localparam logic [2:0] SEL = 3'h5;
    logic clk, rst, scl, sda_low, sda_o, sda_oe;
    logic wp, rprot, pprot, mem_we, busy, standby;
    logic [2:0] sel;
    logic [7:0] mem_addr, mem_wdata;
    // Open drain with pull-up
    wire logic sda;
    int error_cnt, compares, cyc;
    // Array writes seen, {addr, data}
    logic [15:0] wq[$];

    assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    sewp_top #(.WR_CYCLES(WRC)) dut (
        .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe),
        .select_pin_2(sel[2]), .select_pin_1(sel[1]),
        .select_pin_0(sel[0]), .wp_pin(wp),
        .reversible_protect_reg(rprot), .permanent_protect_reg(pprot),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .busy(busy), .standby(standby)
    );

    sewp_ctl_model ctl (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));

    // Collect array writes on the falling edge, where they are settled
    always @(negedge clk)
    begin
        if (mem_we === 1'b1)
            wq.push_back({mem_addr, mem_wdata});
        cyc++;
        if (cyc == 40000)
        begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        chk_word({15'h0, g}, {15'h0, e});
    endtask

    // Address byte alone, then stop
    task automatic probe(input logic [7:0] dev, input logic e);
        logic a;
        ctl.start();
        ctl.send(dev, a);
        chk_bit(a, e);
        ctl.stop();
    endtask

    // Write: device byte, word address, n data bytes
    task automatic wr(input logic [3:0] code, input logic [7:0] wa,
                      input int n, input logic [7:0] d0, input logic fin);
        logic a;
        ctl.start();
        ctl.send({code, SEL, 1'b0}, a);
        chk_bit(a, 1'b1);
        ctl.send(wa, a);
        chk_bit(a, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            ctl.send(d0 + 8'(i), a);
            chk_bit(a, 1'b1);
        end
        if (fin)
            ctl.stop();
    endtask

    // Write cycle runs, ends, then nw array writes seen
    task automatic finish_wr(input int nw);
        repeat (6) @(negedge clk);
        chk_bit(busy, 1'b1);
        chk_bit(standby, 1'b0);
        for (int i = 0; i < 1000 && busy !== 1'b0; i++)
            @(negedge clk);
        chk_bit(standby, 1'b1);
        chk_word(16'(wq.size()), 16'(nw));
    endtask

    task automatic final_report();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        logic [7:0] ed;
        rst = 1'b1;
        sel = SEL;
        wp = 1'b0;
        rprot = 1'b0;
        error_cnt = 0;
        compares = 0;
        cyc = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        chk_bit(standby, 1'b1);
        // Byte write with a poll inside the write cycle
        wr(4'ha, 8'h25, 1, 8'h5a, 1'b1);
        probe({4'ha, SEL, 1'b0}, 1'b0);
        finish_wr(1);
        chk_word(wq.pop_front(), 16'h255a);
        probe({4'ha, SEL, 1'b0}, 1'b1);
        $display("test byte_write done");
        // Seventeen bytes from 0x8e wrap inside page 8
        wr(4'ha, 8'h8e, 17, 8'h30, 1'b1);
        finish_wr(16);
        for (int s = 0; s < 16; s++)
        begin
            ed = 8'h30 + 8'((s - 14) & 15) + ((s == 14) ? 8'h10 : 8'h0);
            chk_word(wq.pop_front(), {4'h8, 4'(s), ed});
        end
        $display("test page_wrap done");
        // Pin protection, then lower-half protection
        wp = 1'b1;
        wr(4'ha, 8'h90, 1, 8'h11, 1'b1);
        finish_wr(0);
        wp = 1'b0;
        rprot = 1'b1;
        wr(4'ha, 8'h10, 1, 8'h22, 1'b1);
        finish_wr(0);
        wr(4'ha, 8'h90, 1, 8'h33, 1'b1);
        finish_wr(1);
        chk_word(wq.pop_front(), 16'h9033);
        rprot = 1'b0;
        $display("test protect done");
        // Wrong select, read request, aborted write
        probe({4'ha, ~SEL, 1'b0}, 1'b0);
        probe({4'ha, SEL, 1'b1}, 1'b1);
        wr(4'ha, 8'h40, 1, 8'h44, 1'b0);
        ctl.recover();
        repeat (10) @(negedge clk);
        chk_bit(busy, 1'b0);
        chk_bit(standby, 1'b1);
        chk_word(16'(wq.size()), 16'h0);
        $display("test address_abort done");
        // Program permanent protection, then 0110 is refused
        wr(4'h6, 8'h00, 1, 8'h00, 1'b1);
        finish_wr(0);
        chk_bit(pprot, 1'b1);
        probe({4'h6, SEL, 1'b0}, 1'b0);
        probe({4'ha, SEL, 1'b0}, 1'b1);
        $display("test protect_reg done");
        final_report();
    end
endmodule // sewp_top_tb

`default_nettype wire
